// *** rgc_ctrl.sv ***
// regulator on/off control with serial slave register access
// assumes bus pins, analog flags and straps are asynchronous
`timescale 1ns/100ps
module rgc_ctrl
  import rgc_pkg::*;
#(
  parameter int         DBNC_CYC_P = DBNC_CYC,
  parameter logic [7:0] CHIP_ID_P  = 8'h05  // arbitrary value
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_regulator_enable_pin_n,
  input  wire logic       i_power_mode_pin,
  input  wire logic [1:0] i_input_status_details,
  input  wire rgc_fault_t i_faults,
  input  wire logic       i_addr_option,
  input  wire logic       i_test_unlocked,
  input  wire logic [1:0] i_enable_code_default,
  input  wire logic       i_out_above_rise,
  input  wire logic       i_out_below_fall,
  output logic            o_regulator_on,
  output logic            o_normal_mode,
  output logic            o_regulator_power_good,
  output logic            o_regulator_power_good_oe
);
  localparam int SW = 15;                       // synchronised bits
  localparam int DW = $clog2(DBNC_CYC_P + 1);   // debounce width

  logic [SW-1:0] s1_q, s2_q;         // two-flop synchroniser
  logic          scl_s, sda_s;       // synced bus lines
  logic          scl_p_q, sda_p_q;   // previous bus levels
  logic          pin_s, pin_p_q;     // enable pin, high = released
  logic          pmpin_s;            // synced mode pin
  logic [1:0]    dtls_s, dtls_p_q;   // charger input details
  rgc_fault_t    flt_s;              // synced shutdown causes
  logic          above_s, below_s;   // output comparators
  logic          adr_opt_s, unl_s;   // address strap, test unlock
  logic          act_q, rw_q, drv_q, nack_q;
  logic [3:0]    bit_q;              // bit slot within a byte
  logic [7:0]    sr_q, tx_q, ptr_q;  // shifter, tx byte, pointer
  rgc_phase_t    ph_q;
  logic          scl_rise, scl_fall, start_c, stop_c, adr_hit;
  logic          wr_en, rd_take;
  logic [7:0]    rd_data;
  logic          init_q;             // strap capture done
  logic [1:0]    dflt_q, en_q, pm_q, cmd_q;
  logic [5:0]    cfg_q;              // upper global config bits
  logic [7:0]    gmask_q, cmask_q, wdt_q, ldo_a_q;
  logic [7:0]    evt_g_q, evt_c_q, rcause_q;
  rgc_state_t    st_q;
  logic [7:0]    cnt_q;              // sequence counter
  logic          rst_pend_q, rst_dly_q, rst_done;
  logic [DW-1:0] dbc_q;
  logic          dbc_hit, chg_v_q, chg_rise;
  logic [2:0]    wake_q;             // {sw, charger, pin}
  logic          shut, wake, pok_q, pok_p_q, normal_q;

  // synchronise every asynchronous input but the enable code strap through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // bus lines and enable pin idle high, all else low: no false edges
      s1_q <= 15'h7000;
      s2_q <= 15'h7000;
    end else begin
      s1_q <= {i_scl, i_sda, i_regulator_enable_pin_n,
               i_power_mode_pin, i_input_status_details, i_faults,
               i_out_above_rise, i_out_below_fall, i_addr_option,
               i_test_unlocked};
      s2_q <= s1_q;
    end
  end
  assign {scl_s, sda_s, pin_s, pmpin_s, dtls_s} = s2_q[14:9];
  assign flt_s = s2_q[8:4];
  assign {above_s, below_s, adr_opt_s, unl_s} = s2_q[3:0];

  // previous levels for edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
      pin_p_q  <= 1'b1;
      dtls_p_q <= 2'h0;
      chg_v_q  <= 1'b0;
      pok_p_q  <= 1'b0;
    end else begin
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
      pin_p_q  <= pin_s;
      dtls_p_q <= dtls_s;
      chg_v_q  <= (dtls_s == DTLS_VALID);
      pok_p_q  <= pok_q;
    end
  end

  // bus conditions; clock is only ever sampled
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // address decode against strap and test unlock
  assign adr_hit  = (sr_q[7:1] == (adr_opt_s ? ADR_MAIN1 : ADR_MAIN0))
                  | (unl_s & (sr_q[7:1] == ADR_TEST));
  assign wr_en    = act_q & scl_fall & (bit_q == 4'h8)
                  & (ph_q == PH_DATA) & ~rw_q;
  assign rd_take  = act_q & scl_fall & (bit_q == 4'h9)
                  & (ph_q == PH_DATA) & rw_q & ~nack_q;

  // serial slave: shift, acknowledge, pointer, read data out
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_q <= 1'b0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      nack_q <= 1'b0;
      bit_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      ph_q <= PH_ADDR;
    end else if (start_c) begin       // start or repeated start
      act_q <= 1'b1;
      drv_q <= 1'b0;
      nack_q <= 1'b0;
      bit_q <= 4'h0;
      ph_q <= PH_ADDR;
    end else if (stop_c) begin
      act_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (act_q && scl_rise) begin
      if (bit_q < 4'h8) begin         // data bit in
        sr_q <= {sr_q[6:0], sda_s};
        bit_q <= bit_q + 4'h1;
      end else begin                  // acknowledge slot
        nack_q <= sda_s;
        bit_q <= 4'h9;
      end
    end else if (act_q && scl_fall) begin
      if (bit_q == 4'h8) begin        // byte complete
        case (ph_q)
          PH_ADDR: begin
            if (adr_hit) begin
              drv_q <= 1'b1;
              rw_q <= sr_q[0];
              ph_q <= sr_q[0] ? PH_DATA : PH_PTR;
            end else begin            // not ours: stay silent
              act_q <= 1'b0;
            end
          end
          PH_PTR: begin
            ptr_q <= sr_q;
            drv_q <= 1'b1;
            ph_q <= PH_DATA;
          end
          default: begin
            drv_q <= ~rw_q;           // ack writes, free for master
            if (!rw_q) ptr_q <= ptr_q + 8'h01;
          end
        endcase
      end else if (bit_q == 4'h9) begin
        bit_q <= 4'h0;
        if (rd_take) begin            // next read byte
          tx_q <= rd_data;
          ptr_q <= ptr_q + 8'h01;
          drv_q <= ~rd_data[7];
        end else begin
          drv_q <= 1'b0;
          if (rw_q && ph_q == PH_DATA) act_q <= 1'b0;
        end
      end else if (rw_q && ph_q == PH_DATA) begin
        drv_q <= ~tx_q[3'h7 - bit_q[2:0]];
      end
    end
  end
  assign o_sda    = 1'b0;
  assign o_sda_oe = drv_q;

  // register read mux
  always_comb begin
    if (ptr_q == OFS_GEVT) rd_data = evt_g_q;
    else if (ptr_q == OFS_CEVT) rd_data = evt_c_q;
    else if (ptr_q == OFS_CLOOP) rd_data = 8'h00;
    else if (ptr_q == OFS_CSTAT) rd_data = {4'h0, dtls_s, 2'h0};
    else if (ptr_q == OFS_RCAUSE) rd_data = rcause_q;
    else if (ptr_q == OFS_GSTAT)
      rd_data = {2'h0, pok_q, 2'h0, ~pin_s, 2'h0};
    else if (ptr_q == OFS_GMASK) rd_data = gmask_q;
    else if (ptr_q == OFS_CMASK) rd_data = cmask_q;
    else if (ptr_q == OFS_GCFG) rd_data = {cfg_q, 2'h0};
    else if (ptr_q == OFS_CID) rd_data = CHIP_ID_P;
    else if (ptr_q == OFS_WDT) rd_data = wdt_q;
    else if (ptr_q == OFS_LDO_A) rd_data = ldo_a_q;
    else if (ptr_q == OFS_LDO_B) rd_data = {4'h0, pm_q, en_q};
    else rd_data = 8'h00;
  end

  // writable registers and one-cycle command pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gmask_q <= 8'h00;
      cmask_q <= 8'h00;
      cfg_q <= 6'h00;
      wdt_q <= 8'h00;
      ldo_a_q <= 8'h00;
      pm_q <= 2'h0;
      cmd_q <= CMD_NONE;
    end else begin
      cmd_q <= (wr_en && ptr_q == OFS_GCFG) ? sr_q[1:0] : CMD_NONE;
      if (wr_en) begin
        if (ptr_q == OFS_GMASK) gmask_q <= sr_q;
        else if (ptr_q == OFS_CMASK) cmask_q <= sr_q;
        else if (ptr_q == OFS_GCFG) cfg_q <= sr_q[7:2];
        else if (ptr_q == OFS_WDT) wdt_q <= sr_q;
        else if (ptr_q == OFS_LDO_A) ldo_a_q <= sr_q;
        else if (ptr_q == OFS_LDO_B) pm_q <= sr_q[3:2];
      end
    end
  end

  // enable code: strap after release, reloaded by cold reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q <= 1'b0;
      dflt_q <= EN_OFF;
      en_q <= EN_OFF;
    end else if (!init_q) begin
      init_q <= 1'b1;
      dflt_q <= i_enable_code_default;
      en_q <= i_enable_code_default;
    end else if (rst_done) begin
      en_q <= dflt_q;
    end else if (wr_en && ptr_q == OFS_LDO_B) begin
      en_q <= sr_q[1:0];
    end
  end

  // shutdown and wake conditions
  assign shut = (|flt_s) | (cmd_q != CMD_NONE) | (en_q == EN_OFF);
  assign wake = (en_q == EN_ON)
              | ((en_q == EN_AUTO) & (|wake_q));
  assign rst_done = (st_q == ST_RST) && (cnt_q == 8'(RST_CYC - 1));

  // on/off sequencer; shutdown checked before wake
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_OFF;
      cnt_q <= 8'h00;
    end else begin
      case (st_q)
        ST_OFF: begin
          cnt_q <= 8'h00;
          if (rst_pend_q) st_q <= ST_RST;
          else if (!shut && wake) st_q <= ST_UP;
        end
        ST_UP: begin
          if (shut) begin
            st_q <= ST_DOWN;
            cnt_q <= 8'h00;
          end else if (cnt_q == 8'(SEQ_CYC - 1)) begin
            st_q <= ST_ON;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_ON: begin
          cnt_q <= 8'h00;
          if (shut) st_q <= ST_DOWN;
        end
        ST_DOWN: begin
          if (cnt_q == 8'(SEQ_CYC - 1)) begin
            st_q <= ST_OFF;
            cnt_q <= 8'h00;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin                // cold reset actions
          if (rst_done) begin
            st_q <= ST_OFF;
            cnt_q <= 8'h00;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
      endcase
    end
  end

  // pending cold reset after a reset command
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pend_q <= 1'b0;
      rst_dly_q <= 1'b0;
    end else begin
      rst_dly_q <= rst_done;
      if (cmd_q == CMD_RST) rst_pend_q <= 1'b1;
      else if (rst_done) rst_pend_q <= 1'b0;
    end
  end

  // enable pin debounce, saturating at the limit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) dbc_q <= '0;
    else if (pin_s) dbc_q <= '0;
    else if (dbc_q != DW'(DBNC_CYC_P)) dbc_q <= dbc_q + DW'(1);
  end
  assign dbc_hit  = ~pin_s & (dbc_q == DW'(DBNC_CYC_P - 1));
  assign chg_rise = (dtls_s == DTLS_VALID) & ~chg_v_q;

  // wake flags; any shutdown clears them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_q <= 3'h0;
    end else if (shut) begin
      wake_q <= 3'h0;
    end else begin
      if (dbc_hit && en_q == EN_AUTO) wake_q[0] <= 1'b1;
      if (chg_rise && en_q == EN_AUTO) wake_q[1] <= 1'b1;
      if (rst_dly_q && dflt_q == EN_AUTO) wake_q[2] <= 1'b1;
    end
  end

  // sticky event flags, read clears (not the reset cause), a new event wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_g_q <= 8'h00;
      evt_c_q <= 8'h00;
      rcause_q <= 8'h00;
    end else begin
      evt_g_q <= ((rd_take && ptr_q == OFS_GEVT) ? 8'h00 : evt_g_q)
               | (8'((pok_q ^ pok_p_q)) << GEVT_POK)
               | (8'((pin_s & ~pin_p_q)) << GEVT_PINR)
               | (8'((~pin_s & pin_p_q)) << GEVT_PINF);
      evt_c_q <= ((rd_take && ptr_q == OFS_CEVT) ? 8'h00 : evt_c_q)
               | (8'((dtls_s != dtls_p_q)) << CEVT_DTLS);
      rcause_q <= rcause_q
                | (8'(flt_s.watchdog_expired_flag) << RC_WDT)
                | (8'((cmd_q == CMD_RST)) << RC_SRST)
                | (8'((cmd_q[1])) << RC_SOFF)
                | (8'(flt_s.manual_reset_flag) << RC_MRST)
                | (8'(flt_s.uvlo) << RC_UVLO)
                | (8'(flt_s.ovlo) << RC_OVLO)
                | (8'(flt_s.otemp) << RC_TOVLD);
    end
  end

  // power-good hysteresis, blanked unless fully on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) pok_q <= 1'b0;
    else if (st_q != ST_ON || shut) pok_q <= 1'b0;  // low from first down
    else if (above_s) pok_q <= 1'b1;
    else if (below_s) pok_q <= 1'b0;
  end
  assign o_regulator_power_good    = 1'b0;
  assign o_regulator_power_good_oe = ~pok_q;

  // power mode from code and pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) normal_q <= 1'b0;
    else if (!pm_q[1]) normal_q <= pm_q[0];
    else normal_q <= pmpin_s ^ pm_q[0];
  end
  assign o_normal_mode  = normal_q;
  assign o_regulator_on = (st_q == ST_UP) || (st_q == ST_ON);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_down_run;
    (st_q == ST_DOWN) [*2];
  endsequence

  lockout_off_a: assert property (
    (st_q == ST_ON && (flt_s.uvlo || flt_s.otemp)) |=> s_down_run)
    else $error("lockout did not start power-down");
  cmd_off_a: assert property (
    (st_q == ST_ON && cmd_q == CMD_OFF) |=> st_q == ST_DOWN)
    else $error("power-off command ignored");
  wake_prio_a: assert property (
    (st_q == ST_OFF && shut && !rst_pend_q) |=> st_q == ST_OFF)
    else $error("wake beat shutdown");
  wake_clear_a: assert property (
    shut |=> wake_q == 3'h0)
    else $error("wake flag survived shutdown");
  force_on_a: assert property (
    (st_q == ST_OFF && en_q == EN_ON && !shut && !rst_pend_q)
      |=> st_q == ST_UP ##[1:30] st_q == ST_ON)
    else $error("forced on did not power up");
  pg_blank_a: assert property (
    (st_q == ST_UP || st_q == ST_DOWN) |-> o_regulator_power_good_oe)
    else $error("power-good not blanked");
  mode_fixed_a: assert property (
    (pm_q == 2'h1) ##1 (pm_q == 2'h1) |-> o_normal_mode)
    else $error("normal mode code not applied");
  mode_pin_a: assert property (
    (pm_q == 2'h3 && pmpin_s) |=> (!o_normal_mode || pm_q != 2'h3))
    else $error("inverted mode pin not applied");
  addr_nak_a: assert property (
    (act_q && scl_fall && bit_q == 4'h8 && ph_q == PH_ADDR && !adr_hit)
      |=> !o_sda_oe && !act_q)
    else $error("foreign address acknowledged");
  pin_wake_a: assert property (
    (dbc_hit && en_q == EN_AUTO && !shut) |=> wake_q[0])
    else $error("debounced pin did not set wake");
endmodule // rgc_ctrl

// *** rgc_mst.sv ***
// bus master model: drives the serial clock and pulls the data line
// assumes a pull-up on data and the core clock pacing every phase
`timescale 1ns/100ps
module rgc_mst (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  logic [7:0] rx;   // bits seen in the last byte
  logic       ack;  // slave acknowledged the last byte
  // idle bus: clock stands high, data released
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  // wait a number of core clocks
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // set both lines just after an edge, hold a quarter bit
  task automatic step(input logic c, input logic d);
    o_scl    <= c;
    o_sda_oe <= d;
    w(5);
  endtask
  // one bit: data moves only while the clock is low
  task automatic bit_io(input logic d, output logic s);
    step(1'b0, d);
    step(1'b1, d);
    s = i_sda;
    step(1'b1, d);
    step(1'b0, d);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    w(10);
  endtask
  // one byte out (or in with all ones), then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic mack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~tx[i], b);
      rx[i] = b;
    end
    bit_io(mack, b);
    ack = ~b;
  endtask
endmodule // rgc_mst

// *** rgc_pkg.sv ***
// constants, codes and types for the regulator on/off controller
// assumes a single 250 MHz core clock; all pins arrive asynchronously
package rgc_pkg;
  // core clock
  localparam int CLK_MHZ   = 250;
  // enable pin debounce time and derived count
  localparam int DBNC_US   = 30;
  localparam int DBNC_CYC  = DBNC_US * CLK_MHZ;
  // power-up/down sequence length and derived count
  localparam int SEQ_NS    = 100;
  localparam int SEQ_CYC   = (SEQ_NS * CLK_MHZ) / 1000;
  // cold reset actions duration and derived count
  localparam int RST_NS    = 400;
  localparam int RST_CYC   = (RST_NS * CLK_MHZ) / 1000;
  // register offsets
  localparam logic [7:0] OFS_GEVT   = 8'h00;
  localparam logic [7:0] OFS_CEVT   = 8'h01;
  localparam logic [7:0] OFS_CLOOP  = 8'h02;
  localparam logic [7:0] OFS_CSTAT  = 8'h03;
  localparam logic [7:0] OFS_RCAUSE = 8'h04;
  localparam logic [7:0] OFS_GSTAT  = 8'h05;
  localparam logic [7:0] OFS_GMASK  = 8'h06;
  localparam logic [7:0] OFS_CMASK  = 8'h07;
  localparam logic [7:0] OFS_GCFG   = 8'h08;
  localparam logic [7:0] OFS_CID    = 8'h09;
  localparam logic [7:0] OFS_WDT    = 8'h0A;
  localparam logic [7:0] OFS_LDO_A  = 8'h30;
  localparam logic [7:0] OFS_LDO_B  = 8'h31;
  // field positions
  localparam int GEVT_POK   = 6;
  localparam int GEVT_PINR  = 3;
  localparam int GEVT_PINF  = 2;
  localparam int CEVT_DTLS  = 2;
  localparam int GSTAT_POK  = 5;
  localparam int GSTAT_PIN  = 2;
  localparam int RC_WDT     = 6;
  localparam int RC_SRST    = 5;
  localparam int RC_SOFF    = 4;
  localparam int RC_MRST    = 3;
  localparam int RC_UVLO    = 2;
  localparam int RC_OVLO    = 1;
  localparam int RC_TOVLD   = 0;
  // regulator enable codes
  localparam logic [1:0] EN_OFF  = 2'h0;
  localparam logic [1:0] EN_ON   = 2'h1;
  localparam logic [1:0] EN_AUTO = 2'h2;
  // software power commands
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RST  = 2'h1;
  localparam logic [1:0] CMD_OFF  = 2'h2;
  localparam logic [1:0] CMD_SHIP = 2'h3;
  // charger input debounced-and-valid code
  localparam logic [1:0] DTLS_VALID = 2'h3;
  // slave addresses
  localparam logic [6:0] ADR_MAIN1 = 7'h48;
  localparam logic [6:0] ADR_MAIN0 = 7'h40;
  localparam logic [6:0] ADR_TEST  = 7'h49;
  // shutdown causes from the analog side
  typedef struct packed {
    logic uvlo;
    logic ovlo;
    logic otemp;
    logic watchdog_expired_flag;
    logic manual_reset_flag;
  } rgc_fault_t;
  // on/off sequencer states, gray along off-up-on-down
  typedef enum logic [2:0] {
    ST_OFF  = 3'h0,
    ST_UP   = 3'h1,
    ST_ON   = 3'h3,
    ST_DOWN = 3'h2,
    ST_RST  = 3'h6
  } rgc_state_t;
  // serial transfer phases
  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_PTR  = 2'h1,
    PH_DATA = 2'h3
  } rgc_phase_t;
endpackage

// *** tb.sv ***
// bench for the regulator controller, driven through the serial bus
// assumes rgc_mst as bus master and straps held by the bench
`timescale 1ns/100ps
module tb;
  import rgc_pkg::*;
  localparam int DB = 8;  // short debounce count
  logic       i_clk;      // core clock
  logic       i_rst_n;    // reset, active low
  logic       scl;        // bus clock
  logic       m_oe;       // master pulls data low
  logic       sda;        // resolved data line
  logic       pin_n;      // enable pin, active low
  logic       mpin;       // mode pin
  logic       aopt;       // address strap
  logic       unl;        // test unlock
  logic       above;      // rise comparator
  logic       below;      // fall comparator
  logic [1:0] dtls;       // charger details
  logic [1:0] en_def;     // enable code strap
  rgc_fault_t flt;        // shutdown causes
  logic       sda_oe;     // slave pulls data low
  logic       reg_on;     // regulator running
  logic       nmode;      // normal mode
  logic       pg_oe;      // power good held low
  int         miscompares;
  int         n_tests;
  int         cyc = 0;    // cycles for the timeout
  realtime    t_off;      // last regulator shutdown
  // pull-up line: low while any party pulls
  assign sda = ~(m_oe | sda_oe);
  rgc_ctrl #(.DBNC_CYC_P(DB)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda(), .o_sda_oe(sda_oe), .i_regulator_enable_pin_n(pin_n),
    .i_power_mode_pin(mpin), .i_input_status_details(dtls),
    .i_faults(flt), .i_addr_option(aopt), .i_test_unlocked(unl),
    .i_enable_code_default(en_def), .i_out_above_rise(above),
    .i_out_below_fall(below), .o_regulator_on(reg_on),
    .o_normal_mode(nmode), .o_regulator_power_good(),
    .o_regulator_power_good_oe(pg_oe));
  rgc_mst MST (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  // note each shutdown of the regulator
  always @(negedge reg_on) t_off = $realtime;
  // cut a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wait a bounded time for the regulator to reach a level
  task automatic till(input logic v, input int n);
    for (int i = 0; i < n && reg_on !== v; i++) @(posedge i_clk);
    chk(reg_on, v);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    MST.start();
    MST.xfer(8'h90, 1'b0);
    MST.xfer(p, 1'b0);
    MST.xfer(d, 1'b0);
    MST.stop();
  endtask
  task automatic rd(input logic [7:0] p, m, e);
    MST.start();
    MST.xfer(8'h90, 1'b0);
    MST.xfer(p, 1'b0);
    MST.start();
    MST.xfer(8'h91, 1'b0);
    MST.xfer(8'hFF, 1'b0);
    MST.stop();
    chk(MST.rx & m, e);
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    MST.start();
    MST.xfer({a, 1'b0}, 1'b0);
    MST.stop();
    chk(MST.ack, e);
  endtask
  // enable code comes up at the strap value
  task automatic s_reset();
    rd(OFS_LDO_B, 8'h03, EN_AUTO);
    rd(OFS_CEVT, 8'hFF, 8'h00);
  endtask
  // debounced pin wakes, power good blanked while ramping
  task automatic s_pin();
    above <= 1'b1;
    pin_n <= 1'b0;
    w(4);
    chk(reg_on, 1'b0);
    till(1'b1, 20);
    chk(pg_oe, 1'b1);
    w(30);
    chk(pg_oe, 1'b0);
    above <= 1'b0;
    below <= 1'b1;
    w(6);
    chk(pg_oe, 1'b1);
    below <= 1'b0;
    pin_n <= 1'b1;
    flt.uvlo <= 1'b1;
    till(1'b0, 40);
    flt.uvlo <= 1'b0;
    w(40);
    chk(reg_on, 1'b0);
  endtask
  // only the strap address, test address while unlocked
  task automatic s_addr();
    probe(ADR_MAIN1, 1'b1);
    probe(ADR_MAIN0, 1'b0);
    probe(ADR_TEST, 1'b0);
    unl <= 1'b1;
    probe(ADR_TEST, 1'b1);
    unl  <= 1'b0;
    aopt <= 1'b0;
    probe(ADR_MAIN0, 1'b1);
    probe(ADR_MAIN1, 1'b0);
    aopt <= 1'b1;
    w(4);
  endtask
  // every fault level stops a forced-on regulator
  task automatic s_faults();
    for (int i = 0; i < 5; i++) begin
      wr(OFS_LDO_B, {6'h00, EN_ON});
      till(1'b1, 40);
      flt <= rgc_fault_t'(5'h01 << i);
      till(1'b0, 40);
      flt <= '0;
      wr(OFS_LDO_B, {6'h00, EN_OFF});
    end
    wr(OFS_LDO_B, {6'h00, EN_ON});
    till(1'b1, 40);
    wr(OFS_LDO_B, {6'h00, EN_OFF});
    till(1'b0, 40);
  endtask
  // software commands stop it; cold reset brings it back
  task automatic s_cmd();
    logic [1:0] cmds [3];
    realtime    t0;
    cmds = '{CMD_OFF, CMD_SHIP, CMD_RST};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_LDO_B, {6'h00, EN_OFF});
      wr(OFS_LDO_B, {6'h00, EN_ON});
      till(1'b1, 40);
      t0 = $realtime;
      wr(OFS_GCFG, {6'h00, cmds[i]});
      w(40);
      chk(t_off > t0, 1'b1);
    end
    till(1'b1, 200);
    rd(OFS_LDO_B, 8'h03, EN_AUTO);
  endtask
  // a held fault beats a charger wake; a fresh one wakes
  task automatic s_chg();
    flt.otemp <= 1'b1;
    till(1'b0, 40);
    dtls <= DTLS_VALID;
    w(10);
    flt.otemp <= 1'b0;
    w(40);
    chk(reg_on, 1'b0);
    dtls <= 2'h2;
    w(10);
    dtls <= DTLS_VALID;
    till(1'b1, 40);
  endtask
  // burst write and read with pointer increment, unmapped reads 0
  task automatic s_rw();
    logic [7:0] r0;
    MST.start();
    MST.xfer(8'h90, 1'b0);
    MST.xfer(OFS_LDO_A, 1'b0);
    MST.xfer(8'h5A, 1'b0);
    MST.xfer(8'h00, 1'b0);
    MST.stop();
    MST.start();
    MST.xfer(8'h90, 1'b0);
    MST.xfer(OFS_LDO_A, 1'b0);
    MST.start();
    MST.xfer(8'h91, 1'b0);
    MST.xfer(8'hFF, 1'b1);
    r0 = MST.rx;
    MST.xfer(8'hFF, 1'b0);
    MST.stop();
    chk(r0, 8'h5A);
    chk(MST.rx & 8'h0F, 8'h00);
    chk(reg_on, 1'b0);
    rd(8'h50, 8'hFF, 8'h00);
  endtask
  // each mode code against both pin levels
  task automatic s_mode();
    logic e;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_LDO_B, {4'h0, c[1:0], EN_OFF});
      for (int p = 0; p < 2; p++) begin
        mpin <= p[0];
        w(8);
        e = c[1] ? (p[0] ^ c[0]) : c[0];
        chk(nmode, e);
      end
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // reset, then every scenario in turn
  initial begin
    i_rst_n     = 1'b0;
    pin_n       = 1'b1;
    mpin        = 1'b0;
    aopt        = 1'b1;
    unl         = 1'b0;
    above       = 1'b0;
    below       = 1'b0;
    dtls        = 2'h0;
    flt         = '0;
    en_def      = EN_AUTO;
    miscompares = 0;
    n_tests     = 0;
    t_off       = 0;
    w(16);
    chk(reg_on, 1'b0);
    chk(pg_oe, 1'b1);
    i_rst_n <= 1'b1;
    w(6);
    s_reset();
    s_pin();
    s_addr();
    s_faults();
    s_cmd();
    s_chg();
    s_rw();
    s_mode();
    give_verdict();
  end
endmodule // tb
